// File: rtl/boot_rom_mux_byte_bus.sv
// Purpose: boot ROM reader over a multiplexed address/data byte bus
// Assumes: external latches on the two strobes, ROM drives on enable
// Notes:   the byte bus shows the LED pattern while no read is running
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module boot_rom_mux_byte_bus
  import boot_rom_pkg::*;
#(
  parameter int ACCESS_CYC = ROM_ACCESS_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  clk_en,
  // read request side
  input  wire logic                  rd_req,
  input  wire logic [ROM_ADDR_W-1:0] rd_addr,
  output logic                       rd_ready,
  output logic [BYTE_W-1:0]          rd_data,
  output logic                       rd_valid,
  // status indicators
  input  wire logic                  led_en,
  input  wire logic [BYTE_W-1:0]     led_value,
  // byte bus pins
  input  wire logic [BYTE_W-1:0]     rom_addr_data_bus_in,
  output logic [BYTE_W-1:0]          rom_addr_data_bus_out,
  output logic                       rom_addr_data_bus_oe,
  output logic                       high_addr_latch_strobe_n,
  output logic                       low_addr_latch_strobe_n,
  output logic                       rom_output_enable_n
);

  localparam int CNT_W = $clog2(ACCESS_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rd_state_t               state;
    logic [ROM_ADDR_W-1:0]   addr;
    logic [BYTE_W-1:0]       data;
    logic                    valid;
    logic [BYTE_W-1:0]       led;
    logic                    led_on;
    logic [BYTE_W-1:0]       bus_out;
    logic                    bus_oe;
    logic                    hi_n;
    logic                    lo_n;
    logic                    oe_n;
  } core_t;

  localparam core_t CORE_RESET = '{
    state:   ST_IDLE,
    addr:    ADDR_RESET,
    data:    BUS_RESET,
    valid:   1'b0,
    led:     LED_RESET,
    led_on:  1'b0,
    bus_out: BUS_RESET,
    bus_oe:  1'b0,
    hi_n:    1'b1,
    lo_n:    1'b1,
    oe_n:    1'b1
  };

  core_t r_reg;
  core_t r_next;
  logic  timer_start;
  logic  timer_done;

  // picks the byte the bus shows in a given state
  function automatic logic [BYTE_W-1:0] bus_byte(
    input rd_state_t             st,
    input logic [ROM_ADDR_W-1:0] a,
    input logic [BYTE_W-1:0]     led
  );
    logic [BYTE_W-1:0] b;
    b = BUS_RESET;
    unique case (st)
      ST_HI:   b = a[HI_BYTE_LSB +: BYTE_W];
      ST_LO:   b = a[LO_BYTE_LSB +: BYTE_W];
      ST_IDLE: b = led;
      default: b = BUS_RESET;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // enable hold timer

  rom_wait_timer #(
    .CNT_W (CNT_W)
  ) u_wait (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .start   (timer_start),
    .cycles  (CNT_W'(ACCESS_CYC)),
    .done    (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    r_next      = r_reg;
    timer_start = 1'b0;
    r_next.valid  = 1'b0;
    r_next.led_on = led_en;
    r_next.led    = led_value;
    unique case (r_reg.state)
      ST_IDLE: begin
        if (rd_req) begin
          r_next.addr  = rd_addr;
          r_next.state = ST_HI;
        end
      end
      ST_HI: begin
        r_next.state = ST_LO;
      end
      ST_LO: begin
        r_next.state = ST_READ;
        timer_start  = 1'b1;
      end
      ST_READ: begin
        if (timer_done) begin
          r_next.data  = rom_addr_data_bus_in;
          r_next.valid = 1'b1;
          r_next.state = ST_TURN;
        end
      end
      ST_TURN: begin
        // one idle cycle so the ROM lets go before we drive again
        r_next.state = ST_IDLE;
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
    // pin values follow the coming state, so all pins leave flip-flops
    r_next.hi_n    = (r_next.state != ST_HI);
    r_next.lo_n    = (r_next.state != ST_LO);
    r_next.oe_n    = (r_next.state != ST_READ);
    r_next.bus_oe  = (r_next.state == ST_HI) ||
                     (r_next.state == ST_LO) ||
                     ((r_next.state == ST_IDLE) && r_next.led_on);
    r_next.bus_out = bus_byte(r_next.state, r_next.addr, r_next.led);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r_reg <= CORE_RESET;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_ready                 = (r_reg.state == ST_IDLE);
  assign rd_data                  = r_reg.data;
  assign rd_valid                 = r_reg.valid;
  assign rom_addr_data_bus_out    = r_reg.bus_out;
  assign rom_addr_data_bus_oe     = r_reg.bus_oe;
  assign high_addr_latch_strobe_n = r_reg.hi_n;
  assign low_addr_latch_strobe_n  = r_reg.lo_n;
  assign rom_output_enable_n      = r_reg.oe_n;

  ////////////////////////////////////////////////////////////////////////
  // checks

  localparam int ACC = ACCESS_CYC;

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!resetn || !clk_en);

  sequence s_hi_phase;
    !high_addr_latch_strobe_n && low_addr_latch_strobe_n &&
      rom_output_enable_n;
  endsequence

  sequence s_lo_phase;
    high_addr_latch_strobe_n && !low_addr_latch_strobe_n &&
      rom_output_enable_n;
  endsequence

  sequence s_oe_phase;
    high_addr_latch_strobe_n && low_addr_latch_strobe_n &&
      !rom_output_enable_n;
  endsequence

  a_phase_order: assert property (
    $fell(high_addr_latch_strobe_n) |-> s_hi_phase ##1 s_lo_phase
      ##1 s_oe_phase)
    else $error("strobe phases out of order");

  a_one_phase: assert property (
    $onehot0({~high_addr_latch_strobe_n, ~low_addr_latch_strobe_n,
              ~rom_output_enable_n}))
    else $error("more than one bus phase active");

  a_high_byte: assert property (
    (rd_req && rd_ready) |=> !high_addr_latch_strobe_n &&
      rom_addr_data_bus_oe &&
      rom_addr_data_bus_out == $past(rd_addr[15:8]))
    else $error("high address byte not on bus with its strobe");

  a_low_byte: assert property (
    (rd_req && rd_ready) |-> ##2 (!low_addr_latch_strobe_n &&
      rom_addr_data_bus_oe &&
      rom_addr_data_bus_out == $past(rd_addr[7:0], 2)))
    else $error("low address byte not on bus with its strobe");

  a_oe_release: assert property (
    !rom_output_enable_n |-> !rom_addr_data_bus_oe)
    else $error("bus driven while rom output enable is low");

  a_read_span: assert property (
    $fell(rom_output_enable_n) |-> ##[ACC:ACC] (rd_valid &&
      rom_output_enable_n && !rom_addr_data_bus_oe))
    else $error("read data not returned after enable window");

  a_data_capture: assert property (
    rd_valid |-> rd_data == $past(rom_addr_data_bus_in) &&
      $past(!rom_output_enable_n))
    else $error("read data not taken from bus during enable");

  a_led_drive: assert property (
    (rd_ready && !rd_req && led_en) |=> rom_addr_data_bus_oe &&
      rom_addr_data_bus_out == $past(led_value))
    else $error("led pattern not driven on idle bus");

endmodule

`default_nettype wire

// File: rtl/boot_rom_pkg.sv
// Purpose: shared constants and types for the boot ROM byte-bus port
// Assumes: 200 MHz sys_clk, 16-bit ROM address split into two bytes
// Notes:   ROM access time is a plain default, adjust for the part fitted
`default_nettype none

package boot_rom_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int ROM_ACCESS_NS  = 60;
  // least time, rounded up to whole cycles
  localparam int ROM_ACCESS_CYC =
    (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // widths and field positions
  localparam int ROM_ADDR_W  = 16;
  localparam int BYTE_W      = 8;
  localparam int HI_BYTE_LSB = 8;
  localparam int LO_BYTE_LSB = 0;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  BUS_RESET  = 8'h00;
  localparam logic [7:0]  LED_RESET  = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // read sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HI   = 5'h02,
    ST_LO   = 5'h04,
    ST_READ = 5'h08,
    ST_TURN = 5'h10
  } rd_state_t;

endpackage

`default_nettype wire

// File: rtl/rom_wait_timer.sv
// Purpose: counts the cycles the ROM output enable is held
// Assumes: start is a one-cycle pulse, cycles is at least 1
// Notes:   done is high in the last counted cycle
`default_nettype none

module rom_wait_timer
  import boot_rom_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  done
);

  typedef struct packed {
    logic             active;
    logic [CNT_W-1:0] count;
  } wait_state_t;

  wait_state_t r_reg;
  wait_state_t r_next;

  always_comb begin
    r_next = r_reg;
    if (start) begin
      r_next.active = 1'b1;
      r_next.count  = cycles - CNT_W'(1);
    end else if (r_reg.active) begin
      if (r_reg.count == '0) begin
        r_next.active = 1'b0;
      end else begin
        r_next.count = r_reg.count - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.active && (r_reg.count == '0);

endmodule

`default_nettype wire

// File: verif/rom_latch_model.sv
// Purpose: boot ROM with address latches on the shared byte bus
// Assumes: data ready lag cycles into the enable window
// Notes:   released bus shows the inverse of its last level
`default_nettype none

module rom_latch_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] lag,
  input  wire logic [7:0] dev_out,
  input  wire logic       dev_oe,
  input  wire logic       hi_n,
  input  wire logic       lo_n,
  input  wire logic       oe_n,
  output logic [7:0]      bus_wire,
  output logic            clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hi_reg   = 8'h00;
  logic [7:0] lo_reg   = 8'h00;
  logic [7:0] last_reg = 8'h00;
  logic [3:0] wait_reg = 4'h0;
  logic       clash_reg = 1'b0;

  assign clash = clash_reg;

  always_comb begin
    if (dev_oe) begin
      bus_wire = dev_out;
    end else if (!oe_n && wait_reg >= lag) begin
      bus_wire = hi_reg ^ {lo_reg[6:0], lo_reg[7]} ^ 8'h3C;
    end else begin
      bus_wire = ~last_reg;
    end
  end

  always @(posedge sys_clk) begin
    last_reg <= bus_wire;
    if (!hi_n) hi_reg <= bus_wire;
    if (!lo_n) lo_reg <= bus_wire;
    wait_reg <= oe_n ? 4'h0 : wait_reg + 4'h1;
    if (dev_oe && !oe_n) clash_reg <= 1'b1;
  end
endmodule

`default_nettype wire

// File: verif/tb_boot_rom_mux_byte_bus.sv
// Purpose: self-checking bench for the boot ROM byte-bus reader
// Assumes: short enable window of 2 cycles, clk_en dropped once mid-read
// Notes:   pins are checked cycle by cycle through each do_read read
`default_nettype none

module tb_boot_rom_mux_byte_bus;
  import boot_rom_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 2;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        clk_en  = 1'b1;
  logic        rd_req  = 1'b0;
  logic        led_en  = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  logic [7:0]  led_val = 8'h00;
  logic [3:0]  lag     = 4'h0;
  logic        rd_ready, rd_valid, bus_oe, hi_n, lo_n, oe_n, clash;
  logic [7:0]  rd_data, bus_out, bus_wire;
  int          bad_count = 0;
  int          total_checks = 0;

  boot_rom_mux_byte_bus #(.ACCESS_CYC(N)) u_boot_rom_mux_byte_bus (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .led_en(led_en),
    .led_value(led_val), .rom_addr_data_bus_in(bus_wire),
    .rom_addr_data_bus_out(bus_out), .rom_addr_data_bus_oe(bus_oe),
    .high_addr_latch_strobe_n(hi_n), .low_addr_latch_strobe_n(lo_n),
    .rom_output_enable_n(oe_n));

  rom_latch_model u_rom_latch_model (
    .sys_clk(sys_clk), .lag(lag), .dev_out(bus_out), .dev_oe(bus_oe),
    .hi_n(hi_n), .lo_n(lo_n), .oe_n(oe_n), .bus_wire(bus_wire),
    .clash(clash));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    @(posedge sys_clk);
    #1 chk_bit(hi_n & lo_n & oe_n, 1'b1);
    chk_bit(bus_oe | rd_valid, 1'b0);
    chk_bit(rd_ready, 1'b1);
    chk_byte(rd_data, 8'h00);
  endtask

  // request held through the strobe and enable cycles with a wrong address: refused
  task automatic do_read(input logic [15:0] a);
    @(posedge sys_clk);
    rd_req  <= 1'b1;
    rd_addr <= a;
    #1 chk_bit(rd_ready, 1'b1);
    @(posedge sys_clk);
    rd_addr <= ~a;
    #1 chk_bit(hi_n | ~lo_n | rd_ready, 1'b0);
    chk_bit(hi_n | ~oe_n | ~bus_oe, 1'b0);
    chk_byte(bus_out, a[15:8]);
    @(posedge sys_clk);
    #1 chk_bit(lo_n | ~hi_n | ~oe_n | ~bus_oe, 1'b0);
    chk_byte(bus_out, a[7:0]);
    repeat (N) begin
      @(posedge sys_clk);
      #1 chk_bit(oe_n | bus_oe | ~hi_n | ~lo_n, 1'b0);
    end
    @(posedge sys_clk);
    rd_req <= 1'b0;
    #1 chk_bit(rd_valid & oe_n & ~bus_oe & hi_n, 1'b1);
    chk_byte(rd_data, a[15:8] ^ {a[6:0], a[7]} ^ 8'h3C);
  endtask

  task automatic test_reads;
    logic [15:0] tbl [4];
    tbl = '{16'h0000, 16'hFFFF, 16'h1234, 16'hA55A};
    foreach (tbl[i]) do_read(tbl[i]);
  endtask

  task automatic test_slow;
    lag <= 4'h1;
    do_read(16'h8001);
    lag <= 4'h0;
  endtask

  // clock enable low in the high strobe cycle: pins hold, then resume
  task automatic test_freeze;
    @(posedge sys_clk);
    rd_req  <= 1'b1;
    rd_addr <= 16'hC35A;
    @(posedge sys_clk);
    rd_req <= 1'b0;
    clk_en <= 1'b0;
    repeat (3) begin
      @(posedge sys_clk);
      #1 chk_bit(hi_n | ~lo_n | ~oe_n | rd_ready, 1'b0);
      chk_bit(bus_oe, 1'b1);
      chk_byte(bus_out, 8'hC3);
    end
    @(posedge sys_clk);
    clk_en <= 1'b1;
    #1 chk_byte(bus_out, 8'hC3);
    @(posedge sys_clk);
    #1 chk_bit(lo_n | ~hi_n | ~oe_n | ~bus_oe, 1'b0);
    chk_byte(bus_out, 8'h5A);
    repeat (N + 1) @(posedge sys_clk);
    #1 chk_bit(rd_valid & oe_n & ~bus_oe, 1'b1);
    chk_byte(rd_data, 8'h4B);
  endtask

  task automatic test_led;
    @(posedge sys_clk);
    led_en  <= 1'b1;
    led_val <= 8'h5A;
    repeat (2) @(posedge sys_clk);
    #1 chk_bit(bus_oe, 1'b1);
    chk_byte(bus_out, 8'h5A);
    do_read(16'h0F0F);
    @(posedge sys_clk);
    led_val <= 8'hC3;
    #1 chk_bit(bus_oe & rd_ready & ~rd_valid, 1'b1);
    chk_byte(bus_out, 8'h5A);
    repeat (2) @(posedge sys_clk);
    led_en <= 1'b0;
    #1 chk_byte(bus_out, 8'hC3);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit(bus_oe, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    test_reset;
    test_reads;
    test_slow;
    test_freeze;
    test_led;
    chk_bit(clash, 1'b0);
    end_sim;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    end_sim;
  end
endmodule

`default_nettype wire
